// ### exec_pkg.sv
// How it works
// [RL1] Sixteen-bit immediate from bytes two and three
// [RL2] Long targets reach all 64-Kbyte code
// [RL3] Relative jumps: signed byte from next instruction
// [RL4] Direct byte selects RAM or special register
// [RL5] Indirect operand addressed by register 0/1
// [RL6] Direct bit selects RAM or register bit
// [RL7] Absolute call pushes return, low byte first
// [RL8] Absolute call target keeps page, no flags change
// [RL9] Absolute jump replaces low eleven counter bits
// [RL10] Add sets carry and aux carry
// [RL11] Overflow is carry six xor carry seven
// [RL12] Add-with-carry includes carry, same flags
// [RL13] Adds take register, direct, indirect, immediate
// [RL14] Byte AND stores result, flags untouched
// [RL15] Byte AND has six operand combinations
// [RL16] Read-modify-write reads port latch, not pins
// [RL17] Carry AND clears carry on zero bit
// [RL18] Inverted form uses complement, bit untouched
// [RL19] Carry AND takes only direct bit
// [RL20] Stack pointer resets to 07H, preincrements
// [RL21] Direct below 128 RAM, above special registers
// [RL22] Register number from low opcode bits
package exec_pkg;

  // ****************************************
  // Special registers and fields
  // ****************************************
  localparam logic [7:0] SP_RESET   = 8'h07;
  localparam logic [7:0] SFR_ACC    = 8'hE0;
  localparam logic [7:0] SFR_PSW    = 8'hD0;
  localparam logic [7:0] SFR_SP     = 8'h81;
  localparam logic [7:0] SFR_PORT   = 8'h90;
  localparam logic [7:0] BIT_BASE   = 8'h20;
  localparam int         SFR_POS    = 7;
  localparam int         CARRY_POS  = 7;
  localparam int         AUX_POS    = 6;
  localparam int         OVF_POS    = 2;
  localparam int         BANK_HI    = 4;
  localparam int         BANK_LO    = 3;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OPC_LJMP   = 8'h02;
  localparam logic [7:0] OPC_LONG_CALL  = 8'h12;
  localparam logic [7:0] OPC_SJMP   = 8'h80;
  localparam logic [7:0] OPC_JC     = 8'h40;
  localparam logic [7:0] OPC_JNC    = 8'h50;
  localparam logic [7:0] OPC_ANLC   = 8'h82;
  localparam logic [7:0] OPC_ANLC_N = 8'hB0;
  localparam logic [7:0] OPC_ANL_DA = 8'h52;
  localparam logic [7:0] OPC_ANL_DI = 8'h53;
  localparam logic [4:0] ABS_JMP    = 5'h01;
  localparam logic [4:0] ABS_CALL   = 5'h11;
  localparam logic [3:0] GRP_ADD    = 4'h2;
  localparam logic [3:0] GRP_ADDC   = 4'h3;
  localparam logic [3:0] GRP_ANL    = 4'h5;
  localparam logic [3:0] SRC_IMM    = 4'h4;
  localparam logic [2:0] SRC_IND    = 3'h3;

  // ****************************************
  // Host register port
  // ****************************************
  localparam logic [2:0] HR_CTRL    = 3'h0;
  localparam logic [2:0] HR_STATE   = 3'h1;
  localparam logic [2:0] HR_ACC     = 3'h2;
  localparam logic [2:0] HR_PSW     = 3'h3;
  localparam logic [2:0] HR_SP      = 3'h4;
  localparam logic [2:0] HR_PCL     = 3'h5;
  localparam logic [2:0] HR_PCH     = 3'h6;
  localparam int         RUN_POS    = 0;

  typedef enum logic [5:0] {
    S_FETCH = 6'h01,
    S_OPC   = 6'h02,
    S_B2    = 6'h04,
    S_B3    = 6'h08,
    S_EXEC  = 6'h10,
    S_PUSH  = 6'h20
  } state_e;

endpackage : exec_pkg

// ### byte_adder.sv
`timescale 1ns/1ns
module byte_adder (
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       cin_i,
  output logic      [7:0] sum_o,
  output logic            c7_o,
  output logic            c3_o,
  output logic            ovf_o
);
  logic [4:0] lo;
  logic [3:0] mid;
  logic [1:0] hi;

  // ****************************************
  // Carries out of bits 3, 6 and 7
  // ****************************************
  always_comb begin
    lo    = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
    mid   = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, lo[4]};
    hi    = {1'b0, a_i[7]} + {1'b0, b_i[7]} + {1'b0, mid[3]};
    sum_o = {hi[0], mid[2:0], lo[3:0]};
    c7_o  = hi[1];  // see [RL10]
    c3_o  = lo[4];  // see [RL10]
    ovf_o = hi[1] ^ mid[3];  // see [RL11]
  end
endmodule : byte_adder

// ### exec_core.sv
`timescale 1ns/1ns
module exec_core (
  input  wire logic [2:0]  ADDR_I,
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  output logic      [15:0] PM_ADDR_O,
  input  wire logic [7:0]  PM_DATA_I,
  input  wire logic [7:0]  PORT_PINS_I,
  output logic      [7:0]  PORT_LATCH_O
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                 rst_q1;
  logic                 rst_n;
  exec_pkg::state_e     state;
  logic [15:0]          program_counter;
  logic [15:0]          pm_addr;
  logic [7:0]           opcode;
  logic [7:0]           byte2;
  logic [7:0]           byte3;
  logic [7:0]           acc;
  logic [7:0]           psw;
  logic [7:0]           stack_pointer;
  logic [7:0]           port_latch;
  logic [7:0]           iram [0:255];
  logic                 run;
  logic [7:0]           rdata;
  logic [7:0]           reg_addr;
  logic [7:0]           ind_addr;
  logic [7:0]           src_byte;
  logic [7:0]           bit_addr;
  logic [7:0]           bit_byte;
  logic                 src_bit;
  logic                 is_ajmp;
  logic                 is_acall;
  logic                 is_call;
  logic                 is_add;
  logic                 is_addc;
  logic                 is_anl_a;
  logic                 is_anl_d;
  logic                 is_anlc;
  logic                 take_rel;
  logic                 exec;
  logic                 dwr_en;
  logic [7:0]           dwr_data;
  logic [7:0]           sum;
  logic                 c7;
  logic                 c3;
  logic                 ovf;
  logic                 carry_flag;
  logic [15:0]          next_pc;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [1:0] instr_len(input logic [7:0] op);
    if (op == exec_pkg::OPC_LJMP || op == exec_pkg::OPC_LONG_CALL ||
        op == exec_pkg::OPC_ANL_DI) begin
      return 2'h3;  // see [RL1]
    end
    if (op[4:0] == exec_pkg::ABS_JMP || op[4:0] == exec_pkg::ABS_CALL ||
        op == exec_pkg::OPC_SJMP || op == exec_pkg::OPC_JC ||
        op == exec_pkg::OPC_JNC || op == exec_pkg::OPC_ANLC ||
        op == exec_pkg::OPC_ANLC_N || op == exec_pkg::OPC_ANL_DA) begin
      return 2'h2;
    end
    if ((op[7:4] == exec_pkg::GRP_ADD || op[7:4] == exec_pkg::GRP_ADDC ||
         op[7:4] == exec_pkg::GRP_ANL) &&
        (op[3:0] == exec_pkg::SRC_IMM || op[3:0] == exec_pkg::SRC_IMM + 4'h1)) begin
      return 2'h2;
    end
    return 2'h1;
  endfunction : instr_len

  // Direct space read; rmw picks the port latch over the pins
  function automatic logic [7:0] rd_dir(input logic [7:0] a, input logic rmw);
    if (!a[exec_pkg::SFR_POS]) begin
      return iram[a];  // see [RL21]
    end
    unique case (a)
      exec_pkg::SFR_ACC:  return acc;
      exec_pkg::SFR_PSW:  return psw;
      exec_pkg::SFR_SP:   return stack_pointer;
      exec_pkg::SFR_PORT: return rmw ? port_latch : PORT_PINS_I;  // see [RL16]
      default:            return 8'h00;
    endcase
  endfunction : rd_dir

  function automatic logic [15:0] page_tgt(input logic [15:0] pc_v,
                                           input logic [7:0]  op,
                                           input logic [7:0]  lo);
    return {pc_v[15:11], op[7:5], lo};  // see [RL8] see [RL9]
  endfunction : page_tgt

  // ****************************************
  // Reset release
  // ****************************************
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ****************************************
  // Decode and operands
  // ****************************************
  assign carry_flag = psw[exec_pkg::CARRY_POS];
  assign exec       = (state == exec_pkg::S_EXEC);
  assign reg_addr   = {3'h0, psw[exec_pkg::BANK_HI:exec_pkg::BANK_LO], opcode[2:0]};  // see [RL22]
  assign ind_addr   = {3'h0, psw[exec_pkg::BANK_HI:exec_pkg::BANK_LO], 2'h0, opcode[0]};
  assign is_ajmp    = (opcode[4:0] == exec_pkg::ABS_JMP);
  assign is_acall   = (opcode[4:0] == exec_pkg::ABS_CALL);
  assign is_call    = is_acall || opcode == exec_pkg::OPC_LONG_CALL;
  assign is_add     = opcode[7:4] == exec_pkg::GRP_ADD && opcode[3:0] >= exec_pkg::SRC_IMM;
  assign is_addc    = opcode[7:4] == exec_pkg::GRP_ADDC && opcode[3:0] >= exec_pkg::SRC_IMM;
  assign is_anl_a   = opcode[7:4] == exec_pkg::GRP_ANL && opcode[3:0] >= exec_pkg::SRC_IMM;
  assign is_anl_d   = opcode == exec_pkg::OPC_ANL_DA || opcode == exec_pkg::OPC_ANL_DI;
  assign is_anlc    = opcode == exec_pkg::OPC_ANLC || opcode == exec_pkg::OPC_ANLC_N;  // see [RL19]
  assign take_rel   = opcode == exec_pkg::OPC_SJMP ||
                      (opcode == exec_pkg::OPC_JC && carry_flag) ||
                      (opcode == exec_pkg::OPC_JNC && !carry_flag);

  // Source byte of add and accumulator AND forms
  always_comb begin
    if (opcode[3]) begin
      src_byte = iram[reg_addr];  // see [RL13] see [RL15]
    end else if (opcode[3:1] == exec_pkg::SRC_IND) begin
      src_byte = iram[iram[ind_addr]];  // see [RL5]
    end else if (opcode[3:0] == exec_pkg::SRC_IMM) begin
      src_byte = byte2;
    end else begin
      src_byte = rd_dir(byte2, 1'b0);  // see [RL4]
    end
  end

  // Bit operand: low half in RAM bytes, high half in registers
  always_comb begin
    bit_addr = byte2[exec_pkg::SFR_POS] ? {byte2[7:3], 3'h0}
                                        : exec_pkg::BIT_BASE + {4'h0, byte2[6:3]};  // see [RL6]
    bit_byte = rd_dir(bit_addr, 1'b0);
    src_bit  = bit_byte[byte2[2:0]] ^ (opcode == exec_pkg::OPC_ANLC_N);  // see [RL18]
  end

  // Direct destination of byte AND
  assign dwr_en   = exec && is_anl_d;
  always_comb begin
    dwr_data = rd_dir(byte2, 1'b1) & (opcode[0] ? byte3 : acc);  // see [RL14] see [RL16]
  end

  byte_adder u_adder (
    .a_i   (acc),
    .b_i   (src_byte),
    .cin_i (is_addc && carry_flag),  // see [RL12]
    .sum_o (sum),
    .c7_o  (c7),
    .c3_o  (c3),
    .ovf_o (ovf)
  );

  // ****************************************
  // Fetch sequencer
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state   <= exec_pkg::S_FETCH;
      pm_addr <= 16'h0000;
      opcode  <= 8'h00;
      byte2   <= 8'h00;
      byte3   <= 8'h00;
    end else begin
      unique case (state)
        exec_pkg::S_FETCH: begin
          if (run) begin
            pm_addr <= program_counter;
            state   <= exec_pkg::S_OPC;
          end
        end
        exec_pkg::S_OPC: begin
          opcode <= PM_DATA_I;
          if (instr_len(PM_DATA_I) == 2'h1) begin
            state <= exec_pkg::S_EXEC;
          end else begin
            pm_addr <= program_counter;
            state   <= exec_pkg::S_B2;
          end
        end
        exec_pkg::S_B2: begin
          byte2 <= PM_DATA_I;
          if (instr_len(opcode) == 2'h3) begin
            pm_addr <= program_counter;
            state   <= exec_pkg::S_B3;
          end else begin
            state <= exec_pkg::S_EXEC;
          end
        end
        exec_pkg::S_B3: begin
          byte3 <= PM_DATA_I;
          state <= exec_pkg::S_EXEC;
        end
        exec_pkg::S_EXEC: begin
          state <= is_call ? exec_pkg::S_PUSH : exec_pkg::S_FETCH;
        end
        exec_pkg::S_PUSH: begin
          state <= exec_pkg::S_FETCH;
        end
      endcase
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  always_comb begin
    next_pc = program_counter;
    if (state == exec_pkg::S_FETCH && run) begin
      next_pc = program_counter + 16'h0001;
    end else if (state == exec_pkg::S_OPC && instr_len(PM_DATA_I) != 2'h1) begin
      next_pc = program_counter + 16'h0001;
    end else if (state == exec_pkg::S_B2 && instr_len(opcode) == 2'h3) begin
      next_pc = program_counter + 16'h0001;
    end else if (exec && is_ajmp) begin
      next_pc = page_tgt(program_counter, opcode, byte2);  // see [RL9]
    end else if (exec && opcode == exec_pkg::OPC_LJMP) begin
      next_pc = {byte2, byte3};  // see [RL1] see [RL2]
    end else if (exec && take_rel) begin
      next_pc = program_counter + {{8{byte2[7]}}, byte2};  // see [RL3]
    end else if (state == exec_pkg::S_PUSH) begin
      next_pc = is_acall ? page_tgt(program_counter, opcode, byte2)
                         : {byte2, byte3};  // see [RL8] see [RL2]
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      program_counter <= 16'h0000;
    end else begin
      program_counter <= next_pc;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 8'h00;
    end else if (exec && (is_add || is_addc)) begin
      acc <= sum;  // see [RL10] see [RL12]
    end else if (exec && is_anl_a) begin
      acc <= acc & src_byte;  // see [RL14]
    end else if (dwr_en && byte2 == exec_pkg::SFR_ACC) begin
      acc <= dwr_data;
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      psw <= 8'h00;
    end else if (exec && (is_add || is_addc)) begin
      psw[exec_pkg::CARRY_POS] <= c7;  // see [RL10]
      psw[exec_pkg::AUX_POS]   <= c3;  // see [RL10]
      psw[exec_pkg::OVF_POS]   <= ovf;  // see [RL11]
    end else if (exec && is_anlc && !src_bit) begin
      psw[exec_pkg::CARRY_POS] <= 1'b0;  // see [RL17]
    end else if (dwr_en && byte2 == exec_pkg::SFR_PSW) begin
      psw <= dwr_data;
    end
  end

  // ****************************************
  // Stack pointer and port latch
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer <= exec_pkg::SP_RESET;  // see [RL20]
    end else if ((exec && is_call) || state == exec_pkg::S_PUSH) begin
      stack_pointer <= stack_pointer + 8'h01;  // see [RL7] see [RL20]
    end else if (dwr_en && byte2 == exec_pkg::SFR_SP) begin
      stack_pointer <= dwr_data;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      port_latch <= 8'hFF;
    end else if (dwr_en && byte2 == exec_pkg::SFR_PORT) begin
      port_latch <= dwr_data;
    end
  end

  // ****************************************
  // Internal RAM
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (exec && is_call) begin
      iram[stack_pointer + 8'h01] <= program_counter[7:0];  // see [RL7]
    end else if (state == exec_pkg::S_PUSH) begin
      iram[stack_pointer + 8'h01] <= program_counter[15:8];  // see [RL7]
    end else if (dwr_en && !byte2[exec_pkg::SFR_POS]) begin
      iram[byte2] <= dwr_data;  // see [RL21]
    end
  end

  // ****************************************
  // Host register port
  // ****************************************
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'b0;
    end else if (WR_I && ADDR_I == exec_pkg::HR_CTRL) begin
      run <= WDATA_I[exec_pkg::RUN_POS];
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (!RD_I) begin
      rdata <= 8'h00;
    end else begin
      unique case (ADDR_I)
        exec_pkg::HR_CTRL:  rdata <= {7'h00, run};
        exec_pkg::HR_STATE: rdata <= {2'h0, state};
        exec_pkg::HR_ACC:   rdata <= acc;
        exec_pkg::HR_PSW:   rdata <= psw;
        exec_pkg::HR_SP:    rdata <= stack_pointer;
        exec_pkg::HR_PCL:   rdata <= program_counter[7:0];
        exec_pkg::HR_PCH:   rdata <= program_counter[15:8];
        default:            rdata <= 8'h00;
      endcase
    end
  end

  assign RDATA_O      = rdata;
  assign PM_ADDR_O    = pm_addr;
  assign PORT_LATCH_O = port_latch;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  a_stack_reset_value: assert property (  // see [RL20]
    $rose(rst_n) |-> stack_pointer == exec_pkg::SP_RESET)
    else $error("stack pointer not 07H after reset");

  a_call_push_order: assert property (  // see [RL7]
    exec && is_call |=> state == exec_pkg::S_PUSH &&
      stack_pointer == $past(stack_pointer) + 8'h01 &&
      iram[stack_pointer] == $past(program_counter[7:0])
      ##1 stack_pointer == $past(stack_pointer, 2) + 8'h02)
    else $error("call push order wrong");

  a_call_page_kept: assert property (  // see [RL8]
    state == exec_pkg::S_PUSH && is_acall |=>
      program_counter == {$past(program_counter[15:11]), $past(opcode[7:5]),
                          $past(byte2)} && psw == $past(psw, 2))
    else $error("absolute call target or flags wrong");

  a_abs_jump_target: assert property (  // see [RL9]
    exec && is_ajmp |=> program_counter[15:11] == $past(program_counter[15:11]) &&
      program_counter[10:0] == {$past(opcode[7:5]), $past(byte2)})
    else $error("absolute jump target wrong");

  a_long_jump_target: assert property (  // see [RL2]
    exec && opcode == exec_pkg::OPC_LJMP |=>
      program_counter == {$past(byte2), $past(byte3)} ##1 state == exec_pkg::S_OPC)
    else $error("long jump target wrong");

  a_add_carry_out: assert property (  // see [RL10]
    exec && (is_add || is_addc) |=>
      psw[exec_pkg::CARRY_POS] == ({1'b0, $past(acc)} + {1'b0, $past(src_byte)} +
        {8'h00, $past(is_addc && carry_flag)} > 9'h0FF))
    else $error("add carry flag wrong");

  a_add_signed_ovf: assert property (  // see [RL11]
    exec && (is_add || is_addc) |=> psw[exec_pkg::OVF_POS] ==
      ($past(acc[7]) == $past(src_byte[7]) && acc[7] != $past(acc[7])))
    else $error("overflow flag wrong");

  a_anl_keeps_flags: assert property (  // see [RL14]
    exec && is_anl_a |=> psw == $past(psw) && acc == ($past(acc) & $past(src_byte)))
    else $error("byte AND result or flags wrong");

  a_carry_and_clear: assert property (  // see [RL17]
    exec && is_anlc |=> psw[exec_pkg::CARRY_POS] ==
      ($past(carry_flag) && $past(src_bit)) && acc == $past(acc))
    else $error("carry AND wrong");

endmodule : exec_core

// ### prog_mem.sv
`timescale 1ns/1ns
module prog_mem (
  input  wire logic [15:0] addr_i,
  output logic      [7:0]  data_o
);
  // ****************************************
  // Combinational code store
  // ****************************************
  logic [7:0] mem [0:65535];

  assign data_o = mem[addr_i];
endmodule : prog_mem

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk;
  logic        rstn;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [15:0] pm_addr;
  logic [7:0]  pm_data;
  logic [7:0]  pins;
  logic [7:0]  latch;
  int          errors;
  int          n_tests;

  exec_core dut_u (
    .ADDR_I      (addr),
    .CLK_I       (clk),
    .RSTN_I      (rstn),
    .WDATA_I     (wdata),
    .WR_I        (wr),
    .RD_I        (rd),
    .RDATA_O     (rdata),
    .PM_ADDR_O   (pm_addr),
    .PM_DATA_I   (pm_data),
    .PORT_PINS_I (pins),
    .PORT_LATCH_O(latch)
  );

  prog_mem rom_u (
    .addr_i(pm_addr),
    .data_o(pm_data)
  );

  // ****************************************
  // Clock and helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic host_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : host_wr

  task automatic host_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : host_rd

  task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_rd(a, v);
    chk(what, v, exp);
  endtask : expect_reg

  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic load(input logic [15:0] a, input logic [127:0] b);
    for (int i = 0; i < 16; i++) begin
      rom_u.mem[a + 16'(i)] = b[127 - 8 * i -: 8];
    end
  endtask : load

  // Reset, start the core and poll the counter until it parks at stop
  task automatic run_to(input string name, input logic [15:0] stop);
    logic [7:0] lo;
    logic [7:0] hi;
    int         k;
    do_reset();
    host_wr(exec_pkg::HR_CTRL, 8'h01);
    for (k = 0; k < 300; k++) begin
      host_rd(exec_pkg::HR_PCL, lo);
      host_rd(exec_pkg::HR_PCH, hi);
      if ({hi, lo} === stop) break;
      @(posedge clk);
    end
    if (k == 300) begin
      errors++;
      $display("mismatch pc of %s expected %h seen %h", name, stop, {hi, lo});
      print_verdict();
    end
  endtask : run_to

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    rstn    = 1'b0;
    addr    = 3'h0;
    wdata   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    pins    = 8'h00;
    errors  = 0;
    n_tests = 0;

    do_reset();
    chk("pm addr", pm_addr[7:0], 8'h00);
    expect_reg("sp", exec_pkg::HR_SP, 8'h07);
    expect_reg("acc", exec_pkg::HR_ACC, 8'h00);
    expect_reg("psw", exec_pkg::HR_PSW, 8'h00);
    expect_reg("pch", exec_pkg::HR_PCH, 8'h00);
    expect_reg("state", exec_pkg::HR_STATE, 8'h01);
    @(posedge clk);
    #1;
    chk("rdata idle", rdata, 8'h00);
    expect_reg("unmapped", 3'h7, 8'h00);
    host_wr(exec_pkg::HR_SP, 8'h55);
    expect_reg("sp kept", exec_pkg::HR_SP, 8'h07);
    host_wr(exec_pkg::HR_CTRL, 8'h00);
    expect_reg("ctrl", exec_pkg::HR_CTRL, 8'h00);
    chk("latch reset", latch, 8'hFF);
    $display("test registers done");

    // Plain add with carry out of bit 7 only
    load(16'h0000, 128'h24C3_24AA_80FE_0000_0000_0000_0000_0000);
    run_to("add", 16'h0004);
    expect_reg("add acc", exec_pkg::HR_ACC, 8'h6D);
    expect_reg("add psw", exec_pkg::HR_PSW, 8'h84);
    $display("test add done");

    // Add with carry, byte AND, carry AND forms, jump if no carry
    load(16'h0000, 128'h24C3_24AA_34AA_54F0_82E4_B0E0_82E0_5002);
    load(16'h0010, 128'h2401_80FE_0000_0000_0000_0000_0000_0000);
    run_to("addc", 16'h0012);
    expect_reg("addc acc", exec_pkg::HR_ACC, 8'h10);
    expect_reg("addc psw", exec_pkg::HR_PSW, 8'h40);
    expect_reg("addc sp", exec_pkg::HR_SP, 8'h07);
    $display("test addc done");

    // Port read-modify-write uses the latch, plain read uses pins
    @(posedge clk);
    pins <= 8'h55;
    load(16'h0000, 128'h5390_0F25_9080_FE00_0000_0000_0000_0000);
    run_to("port", 16'h0005);
    chk("latch", latch, 8'h0F);
    expect_reg("port acc", exec_pkg::HR_ACC, 8'h55);
    expect_reg("port psw", exec_pkg::HR_PSW, 8'h00);
    $display("test port done");

    // Long jump, page call with push, RAM read back, page jump
    load(16'h0000, 128'h0212_3400_0000_0000_0000_0000_0000_0000);
    load(16'h1234, 128'h7145_0000_0000_0000_0000_0000_0000_0000);
    load(16'h1345, 128'h2508_2509_2156_0000_0000_0000_0000_0000);
    load(16'h1156, 128'h80FE_0000_0000_0000_0000_0000_0000_0000);
    run_to("call", 16'h1156);
    expect_reg("call sp", exec_pkg::HR_SP, 8'h09);
    expect_reg("call acc", exec_pkg::HR_ACC, 8'h48);
    expect_reg("call psw", exec_pkg::HR_PSW, 8'h00);
    $display("test call done");

    // Long call onto a cleared stack, register and indirect sources, jump if carry
    load(16'h0000, 128'h5381_0001_FF00_0000_0000_0000_0000_0000);
    load(16'h00FF, 128'h1202_0000_0000_0000_0000_0000_0000_0000);
    load(16'h0200, 128'h2729_24FE_4002_2410_5201_2501_80FE_0000);
    run_to("long_call", 16'h020C);
    chk("pm addr hi", pm_addr[15:8], 8'h02);
    expect_reg("long_call acc", exec_pkg::HR_ACC, 8'h01);
    expect_reg("long_call sp", exec_pkg::HR_SP, 8'h02);
    expect_reg("long_call psw", exec_pkg::HR_PSW, 8'h00);
    $display("test long_call done");

    print_verdict();
  end
endmodule : testbench
